// >>> bench/float_status_props.sv
// Port-level checks for the float status and exception block.
`timescale 1ns/1ns
module float_status_props #(
    parameter ADDR_W = 16
) (
    input wire core_clk,
    input wire rst,
    input wire load_status_op,
    input wire [15:0] loadData,
    input wire instrDone,
    input wire [ADDR_W-1:0] instrAddr,
    input wire faultOpcode,
    input wire faultDivZero,
    input wire faultOverflow,
    input wire faultUnderflow,
    input wire convOp,
    input wire operandFromAccum,
    input wire [63:0] resultOut,
    input wire resultValid,
    input wire [15:0] arith_status_word,
    input wire [3:0] exc_code_reg,
    input wire [ADDR_W-1:0] exc_addr_reg,
    input wire double_prec_sel,
    input wire irqReq,
    input wire [8:0] irqVector,
    input wire abortExec
);
default clocking cb @(posedge core_clk); endclocking
default disable iff (rst);
wire take = instrDone && !load_status_op;
wire ovfOnly = take && faultOverflow && !faultOpcode && !faultDivZero
    && !faultUnderflow && !convOp && !abortExec;
property p_errSticky; arith_status_word[15] && !load_status_op
    |=> arith_status_word[15]; endproperty
a_errSticky: assert property (p_errSticky) else $error("err lost");
property p_divCapture; take && faultDivZero && !faultOpcode
    |=> arith_status_word[15] && exc_code_reg == 4'h4
    && exc_addr_reg == $past(instrAddr); endproperty
a_divCapture: assert property (p_divCapture) else $error("div");
property p_maskIrq; arith_status_word[14] |=> !irqReq; endproperty
a_maskIrq: assert property (p_maskIrq) else $error("masked irq");
property p_unused; arith_status_word[13:12] == 2'b00
    && !arith_status_word[4]; endproperty
a_unused: assert property (p_unused) else $error("unused bit");
property p_modeLoad; load_status_op |=> arith_status_word[7:5]
    == $past(loadData[7:5]) && double_prec_sel == arith_status_word[7];
endproperty
a_modeLoad: assert property (p_modeLoad) else $error("mode");
property p_vector; irqReq |-> irqVector == 9'h0a4; endproperty
a_vector: assert property (p_vector) else $error("vector");
property p_ovfOff; ovfOnly && !arith_status_word[9]
    |=> resultOut == 64'h0 && !irqReq; endproperty
a_ovfOff: assert property (p_ovfOff) else $error("ovf off");
property p_ovfOn; ovfOnly && arith_status_word[9] && !arith_status_word[14]
    |=> irqReq && exc_code_reg == 4'h8; endproperty
a_ovfOn: assert property (p_ovfOn) else $error("ovf on");
property p_accMode; operandFromAccum |-> !abortExec; endproperty
a_accMode: assert property (p_accMode) else $error("acc trap");
property p_negZero; resultValid && resultOut[63]
    && resultOut[62:55] == 8'h00 |-> irqReq; endproperty
a_negZero: assert property (p_negZero) else $error("neg zero");
endmodule
bind float_status_exception_ctrl float_status_props #(.ADDR_W(ADDR_W))
    float_status_props_inst (.*);

// >>> bench/host_exec_model.sv
// Behavioural model of the instruction engine driving the block.
`timescale 1ns/1ns
module host_exec_model (
    input wire core_clk,
    input wire abortExec,
    output reg instrDone,
    output reg [15:0] instrAddr,
    output reg resNeg,
    output reg resZero,
    output reg faultOpcode,
    output reg faultDivZero,
    output reg faultOverflow,
    output reg faultUnderflow,
    output reg convOp,
    output reg operandCheck,
    output reg operandFromAccum,
    output reg [32:0] convValue,
    output reg [63:0] operandData
);
reg sawAbort = 1'b0;
initial begin
    {instrDone, resNeg, resZero, faultOpcode, faultDivZero} = 5'h00;
    {faultOverflow, faultUnderflow, convOp, operandCheck} = 4'h0;
    operandFromAccum = 1'b0;
    instrAddr = 16'h0000;
    {convValue, operandData} = 97'h0;
end
always @(posedge core_clk) if (instrDone) sawAbort <= abortExec;
// Address and operand data are scrambled and faults cleared once the completion pulse is over.
task issue(input [8:0] f, input [63:0] d, input [15:0] a);
    @(negedge core_clk);
    instrDone = 1'b1;
    instrAddr = a;
    operandData = d;
    convValue = d[32:0];
    {faultOpcode, faultDivZero, faultOverflow, faultUnderflow, resNeg,
        resZero, convOp, operandCheck, operandFromAccum} = f;
    @(negedge core_clk);
    instrDone = 1'b0;
    {faultOpcode, faultDivZero, faultOverflow, faultUnderflow} = 4'h0;
    instrAddr = ~a;
    operandData = ~d;
    convValue = ~d[32:0];
endtask
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the float status and exception block.
`timescale 1ns/1ns
`define CHK(a,e) begin check_count++; if ((a) !== (e)) begin err_total++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
reg core_clk = 0, rst = 1, load_status_op = 0, accWrite = 0;
reg [15:0] loadData = 0;
reg [2:0] accWriteSel = 0, accReadSel = 0;
reg [63:0] accWriteData = 0;
reg resOverrange = 0, resCarry = 0;
reg [8:0] rawExponent = 0;
wire [63:0] accReadData, resultOut, operandData;
wire [15:0] arith_status_word, instrAddr, exc_addr_reg;
wire [32:0] convValue;
wire [8:0] irqVector;
wire [3:0] exc_code_reg;
wire instrDone, resNeg, resZero, faultOpcode, faultDivZero, faultOverflow;
wire faultUnderflow, convOp, operandCheck, operandFromAccum, resultValid;
wire double_prec_sel, long_int_sel, chop_sel, irqReq, abortExec;
int err_total = 0, check_count = 0, cyc = 0, i;
reg [15:0] en [0:5] = '{16'h0, 16'h0, 16'h0100, 16'h0200, 16'h0400, 16'h0800};
reg [8:0] fs [0:5] = '{9'h100, 9'h080, 9'h004, 9'h040, 9'h020, 9'h002};
reg [3:0] cd [0:5] = '{4'h2, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc};
localparam [63:0] NEG0 = 64'h8000_0000_0000_0000;
float_status_exception_ctrl float_status_exception_ctrl_inst (.*);
host_exec_model host_exec_model_inst (.*);
initial forever #10 core_clk = ~core_clk;
always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
        err_total++;
        results;
    end
end
task results;
    $display("errors=%0d checks=%0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
endtask
task load(input [15:0] v);
    @(negedge core_clk);
    load_status_op = 1;
    loadData = v;
    @(negedge core_clk);
    load_status_op = 0;
    loadData = ~v;
endtask
initial begin
    repeat (6) @(negedge core_clk);
    rst = 0;
    `CHK(arith_status_word, 16'h0000)
    load(16'hffff);
    `CHK(arith_status_word, 16'hcfef)
    `CHK({double_prec_sel, long_int_sel, chop_sel}, 3'b111)
    load(16'h00a0);
    `CHK({double_prec_sel, long_int_sel, chop_sel}, 3'b101)
    for (i = 0; i < 6; i++) begin
        load(en[i]);
        host_exec_model_inst.issue(fs[i], 64'h8000 | NEG0,
            16'h0100 + i);
        `CHK(irqReq, 1'b1)
        `CHK(exc_code_reg, cd[i])
        `CHK(exc_addr_reg, 16'h0100 + i)
        `CHK(irqVector, 9'h0a4)
    end
    `CHK(host_exec_model_inst.sawAbort, 1'b1)
    load(16'h4000);
    host_exec_model_inst.issue(9'h080, 64'h0, 16'h0200);
    `CHK({irqReq, exc_code_reg}, 5'h04)
    host_exec_model_inst.issue(9'h000, 64'h0, 16'h0201);
    `CHK(arith_status_word[15], 1'b1)
    load(16'h0000);
    `CHK(arith_status_word[15], 1'b0)
    for (i = 0; i < 2; i++) begin
        host_exec_model_inst.issue(9'h040 >> i, 64'h0, 16'h0300);
        `CHK({irqReq, resultValid, resultOut}, {2'b01, 64'h0})
        `CHK(exc_code_reg, 4'h4)
    end
    load(16'h0800);
    host_exec_model_inst.issue(9'h003, NEG0, 16'h0400);
    `CHK({host_exec_model_inst.sawAbort, irqReq}, 2'b00)
    load(16'h0000);
    host_exec_model_inst.issue(9'h002, NEG0, 16'h0401);
    `CHK({host_exec_model_inst.sawAbort, irqReq}, 2'b00)
    host_exec_model_inst.issue(9'h010, 64'h0, 16'h0500);
    `CHK(arith_status_word[3:2], 2'b10)
    host_exec_model_inst.issue(9'h008, 64'h0, 16'h0501);
    `CHK(arith_status_word[3:2], 2'b01)
    resOverrange = 1;
    resCarry = 1;
    host_exec_model_inst.issue(9'h004, 64'h0, 16'h0502);
    `CHK(arith_status_word[1:0], 2'b11)
    resOverrange = 0;
    resCarry = 0;
    load(16'h0600);
    accWriteData = 64'h0123456789abcdef;
    rawExponent = 9'h105;
    host_exec_model_inst.issue(9'h040, 64'h0, 16'h0600);
    `CHK({irqReq, resultOut}, {1'b1, 64'h02a3456789abcdef})
    rawExponent = 9'h1f3;
    host_exec_model_inst.issue(9'h020, 64'h0, 16'h0601);
    `CHK({irqReq, resultOut}, {1'b1, 64'h79a3456789abcdef})
    accWriteData = 64'h8000000000001234;
    rawExponent = 9'h100;
    host_exec_model_inst.issue(9'h040, 64'h0, 16'h0602);
    `CHK({irqReq, resultOut}, {1'b1, 64'h8000000000001234})
    load(16'h0000);
    host_exec_model_inst.issue(9'h000, 64'h0, 16'h0603);
    `CHK({irqReq, resultValid, resultOut}, {2'b01, 64'h0})
    @(negedge core_clk);
    accWrite = 1;
    accWriteSel = 5;
    accWriteData = 64'h0123456789abcdef;
    @(negedge core_clk);
    accWrite = 0;
    accReadSel = 5;
    @(negedge core_clk);
    `CHK(accReadData, 64'h0123456789abcdef)
    accReadSel = 6;
    @(negedge core_clk);
    `CHK(accReadData, 64'h0)
    results;
end
endmodule

// >>> design/float_status_consts.vh
// Constants for the floating-point status and exception control block.
// Summary of operation
// RULE1 - Six 64-bit accumulators hold single and double floating operands.
// RULE2 - Status bit 07 set selects double precision, clear selects single.
// RULE3 - Status bit 06 set selects 32-bit integers, clear selects 16-bit.
// RULE4 - Status bit 05 set chops results, clear rounds them.
// RULE5 - Bit 15 sets on divide by zero, bad opcode or enabled fault.
// RULE6 - Only a status load clears the sticky error bit; reset does not. Here reset also clears it, loading status_reg with 16'h0000.
// RULE7 - Status bit 14 set suppresses every floating-point interrupt.
// RULE8 - Divide by zero and bad opcode are masked only by bit 14.
// RULE9 - Bit 11 set traps negative zero memory operands before execution.
// RULE10 - Negative zero in an accumulator operand never raises the trap.
// RULE11 - With bit 11 clear negative zero loads and computes without fault.
// RULE12 - A negative zero result is written only with an interrupt.
// RULE13 - Bit 10 set: underflow interrupts, exponent stored 400 octal high.
// RULE14 - Bit 10 clear: underflow gives exact zero without interrupt.
// RULE15 - Bit 09 set: overflow interrupts, exponent stored 400 octal low.
// RULE16 - Bit 09 clear: overflow gives exact zero without interrupt.
// RULE17 - Failed conversion writes zero; interrupts only when bit 08 set.
// RULE18 - Conversion fails when the integer exceeds the selected width.
// RULE19 - Each instruction updates error and condition bits; load sets modes.
// RULE20 - Four condition codes carry, overflow, zero, negative like the CPU.
// RULE21 - Bits 03 negative, 02 zero, 01 overflow, 00 conversion carry.
// RULE22 - Four-bit exception code plus faulting instruction address captured.
// RULE23 - Code and address update on forced or enabled faults despite mask.
// RULE24 - All floating exceptions share one vector at octal 244.
// RULE25 - Status word is 16 bits; bits 13, 12 and 04 read zero.
`ifndef FLOAT_STATUS_CONSTS_VH
`define FLOAT_STATUS_CONSTS_VH
`define STAT_ERR 15
`define STAT_MASK 14
`define STAT_UNDEF_EN 11
`define STAT_UNDER_EN 10
`define STAT_OVER_EN 9
`define STAT_CONV_EN 8
`define STAT_DOUBLE 7
`define STAT_LONG 6
`define STAT_CHOP 5
`define STAT_NEG 3
`define STAT_ZERO 2
`define STAT_OVR 1
`define STAT_CARRY 0
`define STAT_WRITE_MASK 16'hcfef
`define STAT_RESET 16'h0000
`define EXC_OPCODE 4'h2
`define EXC_DIVZERO 4'h4
`define EXC_CONVERT 4'h6
`define EXC_OVERFLOW 4'h8
`define EXC_UNDERFLOW 4'ha
`define EXC_UNDEF 4'hc
`define EXC_VECTOR 9'h0a4
`define EXP_SHIFT 9'h100
`define ACCUM_COUNT 6
`endif

// >>> design/float_status_exception_ctrl.v
// Status word, exception capture and accumulator file of the float unit.
`timescale 1ns/1ns
`include "float_status_consts.vh"
module float_status_exception_ctrl #(
    parameter ADDR_W = 16,
    parameter INT_W_SHORT = 16,
    parameter INT_W_LONG = 32
) (
    input wire core_clk,
    input wire rst,
    input wire load_status_op,
    input wire [15:0] loadData,
    input wire instrDone,
    input wire [ADDR_W-1:0] instrAddr,
    input wire resNeg,
    input wire resZero,
    input wire resOverrange,
    input wire resCarry,
    input wire faultOpcode,
    input wire faultDivZero,
    input wire faultOverflow,
    input wire faultUnderflow,
    input wire [32:0] convValue,
    input wire convOp,
    input wire operandCheck,
    input wire operandFromAccum,
    input wire [63:0] operandData,
    input wire [8:0] rawExponent,
    input wire accWrite,
    input wire [2:0] accWriteSel,
    input wire [63:0] accWriteData,
    input wire [2:0] accReadSel,
    output reg [63:0] accReadData,
    output reg [63:0] resultOut,
    output reg resultValid,
    output wire [15:0] arith_status_word,
    output wire [3:0] exc_code_reg,
    output wire [ADDR_W-1:0] exc_addr_reg,
    output wire double_prec_sel,
    output wire long_int_sel,
    output wire chop_sel,
    output reg irqReq,
    output wire [8:0] irqVector,
    output wire abortExec
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    reg [15:0] status_reg;
    reg [15:0] status_next;
    reg [3:0] excCode_reg;
    reg [3:0] excCode_next;
    reg [ADDR_W-1:0] excAddr_reg;
    reg [ADDR_W-1:0] excAddr_next;
    reg [63:0] acc_reg [0:`ACCUM_COUNT-1];
    reg [63:0] result_next;
    reg irq_next;
    reg enabledFault;
    reg [3:0] faultCode;
    reg convFail;
    reg undefTrap;
    reg [7:0] storedExp;
    reg [8:0] expAdjusted;
    reg [3:0] condNext;
    wire maskAll = status_reg[`STAT_MASK];
    wire negZeroOperand;
    wire irqFire;
    wire [32:0] shortSpill;
    wire [32:0] longSpill;
    wire [63:0] zeroWord = 64'h0000000000000000;

    assign arith_status_word = status_reg;
    assign exc_code_reg = excCode_reg;
    assign exc_addr_reg = excAddr_reg;
    assign double_prec_sel = status_reg[`STAT_DOUBLE]; // [RULE2]
    assign long_int_sel = status_reg[`STAT_LONG]; // [RULE3]
    assign chop_sel = status_reg[`STAT_CHOP]; // [RULE4]
    assign irqVector = `EXC_VECTOR; // [RULE24]

    // Negative zero is a set sign with a zero biased exponent.
    assign negZeroOperand = operandData[63] && (operandData[62:55] == 8'h00);

    // ------------------------------------------------------------------
    // Conversion range
    // ------------------------------------------------------------------
    // A bit spills when it lies at or above the sign position of the
    // chosen integer width and differs from the sign of the full value.
    genvar b;
    generate
        for (b = 0; b < 33; b = b + 1) begin : spillGen
            if (b >= INT_W_SHORT - 1) begin : shortHigh
                assign shortSpill[b] = convValue[b] ^ convValue[32];
            end else begin : shortLow
                assign shortSpill[b] = 1'b0;
            end
            if (b >= INT_W_LONG - 1) begin : longHigh
                assign longSpill[b] = convValue[b] ^ convValue[32];
            end else begin : longLow
                assign longSpill[b] = 1'b0;
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Accumulator file
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < `ACCUM_COUNT; i = i + 1) begin : accGen
            always @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    acc_reg[i] <= 64'h0000000000000000;
                end else if (accWrite && accWriteSel == i) begin
                    acc_reg[i] <= accWriteData; // [RULE1]
                end
            end
        end
    endgenerate

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            accReadData <= 64'h0000000000000000;
        end else if (accReadSel < `ACCUM_COUNT) begin
            accReadData <= acc_reg[accReadSel]; // [RULE1]
        end else begin
            accReadData <= 64'h0000000000000000;
        end
    end

    // ------------------------------------------------------------------
    // Fault classification
    // ------------------------------------------------------------------
    always @* begin
        // Conversion fails when the value does not fit the chosen width.
        if (status_reg[`STAT_LONG]) begin
            convFail = convOp && (|longSpill); // [RULE18]
        end else begin
            convFail = convOp && (|shortSpill); // [RULE18]
        end
        // Accumulator operands never trap; memory ones only when enabled.
        undefTrap = operandCheck && !operandFromAccum && negZeroOperand &&
            status_reg[`STAT_UNDEF_EN]; // [RULE9] [RULE10] [RULE11]
        enabledFault = 1'b1;
        faultCode = 4'h0;
        if (faultOpcode) begin
            faultCode = `EXC_OPCODE; // [RULE8]
        end else if (faultDivZero) begin
            faultCode = `EXC_DIVZERO; // [RULE8]
        end else if (undefTrap) begin
            faultCode = `EXC_UNDEF;
        end else if (convFail) begin
            faultCode = `EXC_CONVERT;
            enabledFault = status_reg[`STAT_CONV_EN]; // [RULE17]
        end else if (faultOverflow) begin
            faultCode = `EXC_OVERFLOW;
            enabledFault = status_reg[`STAT_OVER_EN]; // [RULE15]
        end else if (faultUnderflow) begin
            faultCode = `EXC_UNDERFLOW;
            enabledFault = status_reg[`STAT_UNDER_EN]; // [RULE13]
        end else begin
            enabledFault = 1'b0;
        end
    end

    assign abortExec = instrDone && undefTrap; // [RULE9]

    // An interrupt leaves only for an accepted, enabled and unmasked fault.
    assign irqFire = instrDone && !load_status_op && enabledFault && !maskAll;

    // ------------------------------------------------------------------
    // Condition codes
    // ------------------------------------------------------------------
    // A trapped operand reports as zero and never as negative.
    always @* begin
        condNext = 4'h0;
        condNext[`STAT_NEG] = resNeg && !undefTrap; // [RULE21]
        condNext[`STAT_ZERO] = resZero || undefTrap; // [RULE21]
        condNext[`STAT_OVR] = resOverrange; // [RULE20] [RULE21]
        condNext[`STAT_CARRY] = resCarry && convOp; // [RULE21]
    end

    // ------------------------------------------------------------------
    // Result shaping
    // ------------------------------------------------------------------
    always @* begin
        expAdjusted = rawExponent;
        result_next = resultOut;
        if (faultOverflow) begin
            // The true exponent lies 400 octal above the eight-bit field.
            expAdjusted = rawExponent - `EXP_SHIFT; // [RULE15]
        end else if (faultUnderflow && rawExponent[7:0] != 8'h00) begin
            // A zero biased exponent is already correct and is kept.
            expAdjusted = rawExponent + `EXP_SHIFT; // [RULE13]
        end
        storedExp = expAdjusted[7:0];
        if (instrDone && !undefTrap) begin
            if (convFail) begin
                result_next = zeroWord; // [RULE17]
            end else if ((faultOverflow && !status_reg[`STAT_OVER_EN]) ||
                    (faultUnderflow && !status_reg[`STAT_UNDER_EN])) begin
                result_next = zeroWord; // [RULE14] [RULE16]
            end else if (faultOverflow || faultUnderflow) begin
                result_next = {accWriteData[63], storedExp,
                    accWriteData[54:0]};
            end else begin
                result_next = accWriteData;
            end
            // Negative zero leaves only together with an interrupt.
            if (!irqFire && result_next[63] &&
                    result_next[62:55] == 8'h00) begin
                result_next = zeroWord; // [RULE12]
            end
        end
    end

    // ------------------------------------------------------------------
    // Status word and exception registers
    // ------------------------------------------------------------------
    always @* begin
        status_next = status_reg;
        excCode_next = excCode_reg;
        excAddr_next = excAddr_reg;
        irq_next = 1'b0;
        if (load_status_op) begin
            // Loading and reset are the only ways the sticky bit clears.
            status_next = loadData & `STAT_WRITE_MASK; // [RULE6] [RULE19]
        end else if (instrDone) begin
            status_next[`STAT_NEG:`STAT_CARRY] = condNext; // [RULE21]
            if (enabledFault) begin
                status_next[`STAT_ERR] = 1'b1; // [RULE5] [RULE19]
                excCode_next = faultCode; // [RULE22] [RULE23]
                excAddr_next = instrAddr; // [RULE22] [RULE23]
                irq_next = !maskAll; // [RULE7] [RULE12]
            end
        end
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            status_reg <= `STAT_RESET;
            excCode_reg <= 4'h0;
            excAddr_reg <= {ADDR_W{1'b0}};
            resultOut <= 64'h0000000000000000;
            resultValid <= 1'b0;
            irqReq <= 1'b0;
        end else begin
            status_reg <= status_next; // [RULE25]
            excCode_reg <= excCode_next;
            excAddr_reg <= excAddr_next;
            resultOut <= result_next;
            resultValid <= instrDone && !undefTrap;
            irqReq <= irq_next;
        end
    end

endmodule
